// *** core/rps_patch_unit.sv ***
module rps_patch_unit
  import rps_pkg::*;
(
  // Clock and reset
  input  wire logic         CORE_CLK_IN,
  input  wire logic         RSTN_IN,
  // Shared bus address and data phase
  input  wire logic [31:0]  HADDR_IN,
  input  wire logic [1:0]   HTRANS_IN,
  input  wire logic         HWRITE_IN,
  input  wire logic [2:0]   HSIZE_IN,
  input  wire logic [31:0]  HWDATA_IN,
  input  wire logic         HREADY_IN,
  // Register slave select and answer
  input  wire logic         HSEL_IN,
  output logic [31:0]       HRDATA_OUT,
  output logic              HREADYOUT_OUT,
  output logic              HRESP_OUT,
  // ROM controller read data path
  input  wire logic         ROM_HSEL_IN,
  input  wire logic [31:0]  ROM_HRDATA_IN,
  output logic [31:0]       ROM_HRDATA_OUT
);

  rps_state_s st;
  rps_state_s next_st;

  logic        xfer;
  logic        in_region;
  logic        rom_read;
  logic        fn_hit;
  logic [4:0]  fn_idx;
  logic [1:0]  fn_slot;
  rps_word_t   fn_word;
  logic [15:0] slot_h1;

  assign xfer      = HREADY_IN && HTRANS_IN[HTRANS_ACTIVE];
  assign in_region = ((HADDR_IN >= ROM_LO) && (HADDR_IN <= ROM_HI)) ||
                     ((HADDR_IN >= OTP_LO) && (HADDR_IN <= OTP_HI));
  assign rom_read  = xfer && ROM_HSEL_IN && !HWRITE_IN && in_region;

  rps_func_match u_func_match (
    .addr_word_in (HADDR_IN[31:2]),
    .func_addr_in (st.func_addr),
    .valid_in     (st.valid[ALL_ENTRIES-1:DATA_ENTRIES]),
    .hit_out      (fn_hit),
    .idx_out      (fn_idx),
    .slot_out     (fn_slot)
  );

  // Slot offset into the function table, four bytes per entry
  assign slot_h1 = INS_H1 | {9'h000, fn_idx, 2'h0};

  always_comb begin
    unique case (fn_slot)
      2'h0:    fn_word = {slot_h1, INS_H0};
      2'h1:    fn_word = {INS_H3, INS_H2};
      2'h2:    fn_word = {INS_FILL, INS_H4};
      default: fn_word = {INS_FILL, INS_FILL};
    endcase
  end

  always_comb begin
    next_st = st;
    // Register writes land in the data phase; no wait states, so a write never stalls
    if (st.wr_pend) begin
      unique case (st.wr_off)
        OFF_MATCH_ADDR_0: next_st.data_addr[0] = HWDATA_IN;
        OFF_REPL_DATA_0:  next_st.data_val[0]  = HWDATA_IN;
        OFF_MATCH_ADDR_1: next_st.data_addr[1] = HWDATA_IN;
        OFF_REPL_DATA_1:  next_st.data_val[1]  = HWDATA_IN;
        OFF_VALID:        next_st.valid        = HWDATA_IN[ALL_ENTRIES-1:0];
        default: begin
          if (st.wr_off >= OFF_FUNC_ADDR && st.wr_off < OFF_FUNC_END) begin
            next_st.func_addr[5'((st.wr_off - OFF_FUNC_ADDR) >> 2)] = HWDATA_IN;
          end
        end
      endcase
    end
    if (HREADY_IN) begin
      next_st.wr_pend = HSEL_IN && xfer && HWRITE_IN;
      next_st.wr_off  = {HADDR_IN[9:2], 2'b00};
    end
    // Read answer is prepared in the address phase, so it stands for the whole data phase
    if (HSEL_IN && xfer && !HWRITE_IN) begin
      unique case ({HADDR_IN[9:2], 2'b00})
        OFF_MATCH_ADDR_0: next_st.reg_rdata = next_st.data_addr[0];
        OFF_REPL_DATA_0:  next_st.reg_rdata = next_st.data_val[0];
        OFF_MATCH_ADDR_1: next_st.reg_rdata = next_st.data_addr[1];
        OFF_REPL_DATA_1:  next_st.reg_rdata = next_st.data_val[1];
        OFF_VALID:        next_st.reg_rdata = {10'h000, next_st.valid};
        OFF_TABLE_BASE:   next_st.reg_rdata = FUNC_TABLE_BASE;
        default: begin
          if ({HADDR_IN[9:2], 2'b00} >= OFF_FUNC_ADDR && {HADDR_IN[9:2], 2'b00} < OFF_FUNC_END) begin
            next_st.reg_rdata = next_st.func_addr[5'(HADDR_IN[9:2] - OFF_FUNC_ADDR[9:2])];
          end else begin
            next_st.reg_rdata = 32'h0000_0000;
          end
        end
      endcase
    end
    // Patch decision is taken on the address phase and held through ROM wait states
    if (HREADY_IN) begin
      next_st.patch_sel  = 1'b0;
      next_st.patch_word = ROM_HRDATA_IN;
      if (rom_read) begin
        if (fn_hit) begin
          next_st.patch_sel  = 1'b1;
          next_st.patch_word = fn_word;
        end
        // Data entries outrank function entries; entry one is checked last so it wins
        for (int i = 0; i < DATA_ENTRIES; i++) begin
          if (st.valid[i] && HADDR_IN[31:2] == st.data_addr[i][31:2]) begin
            next_st.patch_sel  = 1'b1;
            next_st.patch_word = st.data_val[i];
          end
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      st.data_addr  <= {DATA_ENTRIES{RST_ADDR}};
      st.data_val   <= {DATA_ENTRIES{RST_DATA}};
      st.func_addr  <= {FUNC_ENTRIES{RST_ADDR}};
      st.valid      <= RST_VALID;
      st.wr_pend    <= 1'b0;
      st.wr_off     <= 10'h000;
      st.reg_rdata  <= 32'h0000_0000;
      st.patch_sel  <= 1'b0;
      st.patch_word <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  assign HRDATA_OUT    = st.reg_rdata;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT     = 1'b0;
  // The mux itself stays combinational on memory data so a miss costs no cycle
  assign ROM_HRDATA_OUT = st.patch_sel ? st.patch_word : ROM_HRDATA_IN;

  // Checks
  sequence s_hit1_read;
    rom_read && st.valid[1] && HADDR_IN[31:2] == st.data_addr[1][31:2];
  endsequence

  sequence s_hit0_only;
    rom_read && st.valid[0] && HADDR_IN[31:2] == st.data_addr[0][31:2] &&
      !(st.valid[1] && HADDR_IN[31:2] == st.data_addr[1][31:2]);
  endsequence

  a_entry_one_wins: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    s_hit1_read |=> ROM_HRDATA_OUT == $past(st.data_val[1]))
    else $error("entry one did not win");

  a_entry_zero_subst: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    s_hit0_only |=> ROM_HRDATA_OUT == $past(st.data_val[0]))
    else $error("entry zero word not substituted");

  a_region_guard: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (xfer && !in_region) |=> !st.patch_sel)
    else $error("patch outside rom or otp");

  a_invalid_ignored: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (xfer && st.valid == '0) |=> !st.patch_sel)
    else $error("patch with no valid entry");

  a_miss_passthru: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (HREADY_IN && !rom_read) |=> ROM_HRDATA_OUT == ROM_HRDATA_IN)
    else $error("miss altered memory data");

  a_write_store: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (HSEL_IN && xfer && HWRITE_IN && HADDR_IN[9:0] == OFF_REPL_DATA_1) ##1 HREADY_IN
      |=> st.data_val[1] == $past(HWDATA_IN))
    else $error("data register write lost");

  a_valid_readback: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (HSEL_IN && xfer && !HWRITE_IN && HADDR_IN[9:0] == OFF_VALID && !st.wr_pend)
      |=> HRDATA_OUT == {10'h000, st.valid})
    else $error("valid register readback wrong");

  a_func_first_word: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (rom_read && fn_hit && fn_slot == 2'h0 &&
      !(|(st.valid[DATA_ENTRIES-1:0]))) |=> ROM_HRDATA_OUT[15:0] == INS_H0)
    else $error("redirect sequence not injected");

  // Function words only; a valid data entry would outrank the injected code
  a_func_second_word: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (rom_read && fn_hit && fn_slot == 2'h1 &&
      !(|(st.valid[DATA_ENTRIES-1:0]))) |=> ROM_HRDATA_OUT == {INS_H3, INS_H2})
    else $error("redirect second word wrong");

  a_func_last_word: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (rom_read && fn_hit && fn_slot == 2'h2 &&
      !(|(st.valid[DATA_ENTRIES-1:0]))) |=> ROM_HRDATA_OUT == {INS_FILL, INS_H4})
    else $error("redirect last word wrong");

  a_valid_store: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (HSEL_IN && xfer && HWRITE_IN && HADDR_IN[9:0] == OFF_VALID) ##1 HREADY_IN
      |=> st.valid == $past(HWDATA_IN[ALL_ENTRIES-1:0]))
    else $error("valid register write lost");

  a_no_wait: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    HREADYOUT_OUT && !HRESP_OUT)
    else $error("slave inserted wait or error");

endmodule : rps_patch_unit

// *** core/rps_pkg.sv ***
package rps_pkg;

  // Entry counts
  localparam int unsigned DATA_ENTRIES = 2;
  localparam int unsigned FUNC_ENTRIES = 20;
  localparam int unsigned ALL_ENTRIES  = DATA_ENTRIES + FUNC_ENTRIES;
  localparam int unsigned FUNC_WORDS   = 3;

  // Register byte offsets inside the patch window
  localparam logic [9:0] OFF_MATCH_ADDR_0 = 10'h000;
  localparam logic [9:0] OFF_REPL_DATA_0  = 10'h004;
  localparam logic [9:0] OFF_MATCH_ADDR_1 = 10'h008;
  localparam logic [9:0] OFF_REPL_DATA_1  = 10'h00c;
  localparam logic [9:0] OFF_VALID        = 10'h010;
  localparam logic [9:0] OFF_TABLE_BASE   = 10'h014;
  localparam logic [9:0] OFF_FUNC_ADDR    = 10'h040;
  localparam logic [9:0] OFF_FUNC_END     = 10'h090;

  // Reset values
  localparam logic [31:0]          RST_ADDR  = 32'h0000_0000;
  localparam logic [31:0]          RST_DATA  = 32'h0000_0000;
  localparam logic [ALL_ENTRIES-1:0] RST_VALID = '0;

  // Patchable regions, inclusive bounds
  localparam logic [31:0] ROM_LO = 32'h07f0_0000;
  localparam logic [31:0] ROM_HI = 32'h07f1_ffff;
  localparam logic [31:0] OTP_LO = 32'h07f8_0000;
  localparam logic [31:0] OTP_HI = 32'h07f8_ffff;

  // Function table sits right after the vector table in system_ram
  localparam logic [31:0] SYSTEM_RAM_BASE = 32'h07fc_0000;
  localparam logic [31:0] VECTOR_TABLE_SZ = 32'h0000_00c0;
  localparam logic [31:0] FUNC_TABLE_BASE = SYSTEM_RAM_BASE + VECTOR_TABLE_SZ;

  // Injected redirect sequence, five halfwords; h1 carries the table slot offset
  localparam logic [15:0] INS_H0   = 16'hb403;
  localparam logic [15:0] INS_H1   = 16'h2000;
  localparam logic [15:0] INS_H2   = 16'h4901;
  localparam logic [15:0] INS_H3   = 16'h5809;
  localparam logic [15:0] INS_H4   = 16'hbd02;
  localparam logic [15:0] INS_FILL = 16'hbf00;

  // AHB transfer type bit that marks NONSEQ or SEQ
  localparam int unsigned HTRANS_ACTIVE = 1;

  typedef logic [31:0] rps_word_t;

  typedef struct packed {
    rps_word_t [DATA_ENTRIES-1:0] data_addr;
    rps_word_t [DATA_ENTRIES-1:0] data_val;
    rps_word_t [FUNC_ENTRIES-1:0] func_addr;
    logic [ALL_ENTRIES-1:0]       valid;
    logic                         wr_pend;
    logic [9:0]                   wr_off;
    rps_word_t                    reg_rdata;
    logic                         patch_sel;
    rps_word_t                    patch_word;
  } rps_state_s;

endpackage : rps_pkg

// *** core/rps_func_match.sv ***
module rps_func_match
  import rps_pkg::*;
(
  // Transfer word address and entries
  input  wire logic [29:0]                    addr_word_in,
  input  wire rps_word_t [FUNC_ENTRIES-1:0]   func_addr_in,
  input  wire logic [FUNC_ENTRIES-1:0]        valid_in,
  // Result
  output logic                                hit_out,
  output logic [4:0]                          idx_out,
  output logic [1:0]                          slot_out
);

  logic [FUNC_ENTRIES-1:0] hit_v;
  logic [FUNC_ENTRIES-1:0][29:0] dist_v;

  // Each entry covers three words of injected code from its own word address
  for (genvar i = 0; i < FUNC_ENTRIES; i++) begin : g_cmp
    assign dist_v[i] = addr_word_in - func_addr_in[i][31:2];
    assign hit_v[i]  = valid_in[i] && (dist_v[i] < 30'(FUNC_WORDS));
  end

  // Highest index wins
  always_comb begin
    hit_out  = 1'b0;
    idx_out  = 5'h00;
    slot_out = 2'h0;
    for (int i = 0; i < FUNC_ENTRIES; i++) begin
      if (hit_v[i]) begin
        hit_out  = 1'b1;
        idx_out  = 5'(i);
        slot_out = dist_v[i][1:0];
      end
    end
  end

endmodule : rps_func_match

// *** verification/rps_rom_model.sv ***
module rps_rom_model (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // Bus address phase
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic        hsel_in,
  input  wire logic        hready_in,
  // Wait states per read and answer
  input  wire logic [1:0]  waits_in,
  output logic [31:0]      rdata_out,
  output logic             ready_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        pend;
  logic [1:0]  cnt;
  logic [31:0] addr;
  logic [7:0]  cyc;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pend <= 1'b0;
      cnt  <= 2'h0;
      addr <= 32'h0;
      cyc  <= 8'h0;
    end else begin
      cyc <= cyc + 8'h1;
      if (hready_in) begin
        pend <= hsel_in & htrans_in[1] & !hwrite_in;
        addr <= haddr_in;
        cnt  <= 2'h0;
      end else begin
        cnt <= cnt + 2'h1;
      end
    end
  end
  assign ready_out = !pend || (cnt >= waits_in);
  // Outside a data phase the bus shows a moving pattern, so stale data never looks right
  assign rdata_out = pend ? ~addr : {4{cyc}};
endmodule : rps_rom_model

// *** verification/test_rps_patch_unit.sv ***
module test_rps_patch_unit;
  timeunit 1ns;
  timeprecision 100ps;
  import rps_pkg::*;
  localparam logic [31:0] REG_BASE = 32'h4008_0000;
  localparam logic [31:0] A0       = 32'h07f0_0100;
  localparam logic [31:0] FW       = 32'h07f1_fff0;
  logic        clk, rstn, hwrite, hsel, rom_hsel, rdy_reg, resp, rdy_rom, hready;
  logic [1:0]  htrans, waits;
  logic [31:0] haddr, hwdata, rom_rdata, hrdata, rom_out;
  int          fail_count, total_checks;
  assign hready = rdy_reg & rdy_rom;
  rps_patch_unit uut (.CORE_CLK_IN(clk), .RSTN_IN(rstn), .HADDR_IN(haddr), .HTRANS_IN(htrans),
    .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready), .HSEL_IN(hsel),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(rdy_reg), .HRESP_OUT(resp), .ROM_HSEL_IN(rom_hsel),
    .ROM_HRDATA_IN(rom_rdata), .ROM_HRDATA_OUT(rom_out));
  rps_rom_model rom (.clk_in(clk), .rstn_in(rstn), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsel_in(rom_hsel), .hready_in(hready), .waits_in(waits),
    .rdata_out(rom_rdata), .ready_out(rdy_rom));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task idle;
    hsel     <= 1'b0;
    rom_hsel <= 1'b0;
    htrans   <= 2'h0;
    hwrite   <= 1'b0;
  endtask : idle
  task wr(input logic [9:0] off, input logic [31:0] val);
    @(posedge clk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, 1'b1, REG_BASE | 32'(off)};
    @(posedge clk);
    idle();
    hwdata <= val;
  endtask : wr
  task rd(input logic [9:0] off, input logic [31:0] exp);
    @(posedge clk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, 1'b0, REG_BASE | 32'(off)};
    @(posedge clk);
    idle();
    @(negedge clk);
    chk(hrdata, exp);
    chk({30'h0, rdy_reg, resp}, 32'h0000_0002);
  endtask : rd
  // The substituted word must hold through every ROM wait state
  task fetch(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk);
    {rom_hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, 1'b0, a};
    @(posedge clk);
    idle();
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      chk(rom_out, exp);
      if (hready) break;
      @(posedge clk);
    end
  endtask : fetch
  initial begin
    #40000;
    fail_count++;
    close_out();
  end
  initial begin
    {rstn, hsel, rom_hsel, htrans, hwrite, waits} = '0;
    {haddr, hwdata, fail_count, total_checks} = '0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 6; i++) rd(10'(4 * i), (i == 5) ? FUNC_TABLE_BASE : 32'h0);
    $display("test reset values done");
    wr(OFF_MATCH_ADDR_0, A0);
    wr(OFF_REPL_DATA_0, 32'hcafe_0000);
    wr(OFF_MATCH_ADDR_1, A0);
    wr(OFF_REPL_DATA_1, 32'hbeef_0001);
    wr(OFF_VALID, 32'hffff_ffff);
    rd(OFF_VALID, 32'h003f_ffff);
    rd(OFF_MATCH_ADDR_0, A0);
    rd(OFF_REPL_DATA_1, 32'hbeef_0001);
    rd(10'h03c, 32'h0);
    wr(OFF_TABLE_BASE, 32'h1234_5678);
    rd(OFF_TABLE_BASE, FUNC_TABLE_BASE);
    $display("test registers done");
    wr(OFF_VALID, 32'h0);
    fetch(A0, ~A0);
    wr(OFF_VALID, 32'h1);
    fetch(A0, 32'hcafe_0000);
    fetch(A0 + 32'h2, 32'hcafe_0000);
    fetch(A0 + 32'h4, ~(A0 + 32'h4));
    wr(OFF_VALID, 32'h3);
    fetch(A0, 32'hbeef_0001);
    waits <= 2'h2;
    fetch(A0, 32'hbeef_0001);
    waits <= 2'h0;
    wr(OFF_MATCH_ADDR_1, 32'h07fc_0200);
    fetch(32'h07fc_0200, ~32'h07fc_0200);
    wr(OFF_MATCH_ADDR_1, 32'h07f2_0000);
    fetch(32'h07f2_0000, ~32'h07f2_0000);
    wr(OFF_MATCH_ADDR_1, 32'h07f8_fffc);
    fetch(32'h07f8_fffc, 32'hbeef_0001);
    $display("test data patch done");
    wr(OFF_VALID, 32'h0);
    wr(OFF_FUNC_ADDR + 10'h04c, FW);
    wr(OFF_FUNC_ADDR, 32'h07f0_0200);
    wr(OFF_VALID, 32'h0020_0004);
    rd(OFF_FUNC_ADDR + 10'h04c, FW);
    fetch(FW, {INS_H1 | 16'h004c, INS_H0});
    fetch(FW + 32'h4, {INS_H3, INS_H2});
    fetch(FW + 32'h8, {INS_FILL, INS_H4});
    fetch(FW + 32'hc, ~(FW + 32'hc));
    fetch(32'h07f0_0200, {INS_H1, INS_H0});
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    rd(OFF_VALID, 32'h0);
    fetch(FW, ~FW);
    $display("test function patch done");
    close_out();
  end
endmodule : test_rps_patch_unit
